// >>> fbr_top.sv
`timescale 1ns/1ps
`include "fbr_regs.svh"
module fbr_top import fbr_pkg::*; #(
  parameter int AW    = 21,
  parameter int DW    = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // Configuration write from the command interface
  input  wire logic          cfg_wr,
  input  wire logic [15:0]   cfg_wdata,
  output logic [15:0]        cfg_rdata,
  // Flash bus from the host
  input  wire logic          chip_en_n,
  input  wire logic          latch_en_n,
  input  wire logic          burst_clk,
  input  wire logic [AW-1:0] addr_in,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  output logic               wait_out,
  // Memory array read port
  output logic               arr_req,
  output logic [AW-1:0]      arr_addr,
  input  wire logic          arr_rvalid,
  input  wire logic [DW-1:0] arr_rdata
);
  fbr_cfg_t      cfg_q, cfg_d;
  fbr_state_e    st_q, st_d;
  logic          kclk_q;
  logic [AW-1:0] start_q, start_d;
  logic [AW-1:0] beat_q, beat_d;
  logic [AW-1:0] fidx_q, fidx_d;
  logic [2:0]    lat_q, lat_d;
  logic [1:0]    wcnt_q, wcnt_d;
  logic          hold_q, hold_d;
  logic          pend_q, pend_d;
  logic          outst_q, outst_d;
  logic          req_q, req_d;
  logic [AW-1:0] raddr_q, raddr_d;
  logic [DW-1:0] dq_q, dq_d;
  logic          oe_q, oe_d;
  logic          wact_q, wact_d;
  logic          wait_q, wait_d;
  logic          act_edge, cont, sync_rd, crossing, pop, flush;
  logic [AW-1:0] nwords;
  logic          f_ready, f_valid;
  logic [DW-1:0] f_data;

  fbr_seq_if #(.AW(AW)) seq ();

  fbr_addr_gen #(.AW(AW)) u_gen (
    .seq (seq.gen)
  );

  // Absorbs array latency; with one read in flight a slow array can still starve the burst
  fbr_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (arr_rvalid && outst_q),
    .in_ready  (f_ready),
    .in_data   (arr_rdata),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  always_comb begin
    seq.start_addr  = start_q;
    seq.index       = fidx_q;
    seq.length      = cfg_q[`FBR_LENGTH_MSB:`FBR_LENGTH_LSB];
    seq.wrap_select = cfg_q[`FBR_WRAP_SELECT_BIT];
    seq.burst_type  = cfg_q[`FBR_BURST_TYPE_BIT];
  end

  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = cfg_wdata & `FBR_CFG_WMASK;
    end
  end

  always_comb begin
    // Clock pin is compared with its sample from the cycle before, so an edge is seen in the cycle it arrives
    act_edge = cfg_q[`FBR_EDGE_SELECT_BIT] ? (burst_clk && !kclk_q)
                                           : (!burst_clk && kclk_q);
    sync_rd  = !cfg_q[`FBR_READ_SELECT_BIT];
    cont     = cfg_q[`FBR_LENGTH_MSB:`FBR_LENGTH_LSB] == `FBR_LEN_CONT;
    case (cfg_q[`FBR_LENGTH_MSB:`FBR_LENGTH_LSB])
      `FBR_LEN_4:  nwords = AW'(4);
      `FBR_LEN_8:  nwords = AW'(8);
      `FBR_LEN_16: nwords = AW'(16);
      default:     nwords = '0;
    endcase
    crossing = (beat_q != '0) && ((start_q[`FBR_ROW_BITS-1:0] + beat_q[`FBR_ROW_BITS-1:0]) == '0);
    st_d     = st_q;
    start_d  = start_q;
    beat_d   = beat_q;
    fidx_d   = fidx_q;
    lat_d    = lat_q;
    wcnt_d   = wcnt_q;
    hold_d   = hold_q;
    pend_d   = pend_q;
    dq_d     = dq_q;
    oe_d     = oe_q;
    pop      = 1'b0;
    flush    = 1'b0;
    case (st_q)
      FBR_ARMED: begin
        if (act_edge) begin
          lat_d = cfg_q[`FBR_LATENCY_MSB:`FBR_LATENCY_LSB];
          st_d  = FBR_LAT;
        end
      end
      FBR_LAT: begin
        if (act_edge) begin
          if (lat_q <= 3'h1) begin
            st_d = FBR_DATA;
            pop  = 1'b1;
          end else begin
            lat_d = lat_q - 3'h1;
          end
        end
      end
      FBR_DATA: begin
        if (act_edge) begin
          if (hold_q) begin
            hold_d = 1'b0;
          end else if (wcnt_q > 2'h1) begin
            wcnt_d = wcnt_q - 2'h1;
          end else if (wcnt_q == 2'h1) begin
            wcnt_d = 2'h0;
            pop    = 1'b1;
          end else if (!cont && beat_q == nwords) begin
            st_d = FBR_DONE;
            oe_d = 1'b0;
          end else if (crossing && pend_q) begin
            wcnt_d = start_q[`FBR_QUAD_BITS-1:0];
            pend_d = 1'b0;
          end else begin
            pop = 1'b1;
          end
        end
      end
      FBR_DONE: begin
        oe_d = 1'b0;
      end
      default: begin
        oe_d = 1'b0;
      end
    endcase
    if (pop) begin
      dq_d   = f_data;
      oe_d   = 1'b1;
      hold_d = cfg_q[`FBR_DATA_HOLD_BIT];
      beat_d = beat_q + AW'(1);
    end
    if (chip_en_n || !sync_rd) begin
      st_d  = FBR_IDLE;
      oe_d  = 1'b0;
      flush = 1'b1;
    end else if (!latch_en_n) begin
      st_d    = FBR_ARMED;
      start_d = addr_in;
      beat_d  = '0;
      fidx_d  = '0;
      hold_d  = 1'b0;
      wcnt_d  = 2'h0;
      oe_d    = 1'b0;
      flush   = 1'b1;
      // Only unaligned continuous bursts or bursts with the wrap bit set ever need the pause
      pend_d  = (cont || cfg_q[`FBR_WRAP_SELECT_BIT])
                && (addr_in[`FBR_QUAD_BITS-1:0] != '0);
    end
  end

  always_comb begin
    outst_d = outst_q;
    req_d   = 1'b0;
    raddr_d = raddr_q;
    if (arr_rvalid) begin
      outst_d = 1'b0;
    end
    // One read in flight keeps the FIFO from overrunning
    if ((st_q == FBR_LAT || st_q == FBR_DATA || st_q == FBR_ARMED) && !outst_q && !req_q && f_ready
        && !flush && (cont || fidx_q < nwords)) begin
      req_d   = 1'b1;
      outst_d = 1'b1;
      raddr_d = seq.addr;
    end
    if (flush) begin
      outst_d = 1'b0;
    end
  end

  always_comb begin
    // Wait is seen with the next state so it can lead by one cycle
    if (!sync_rd) begin
      wact_d = 1'b1;
    end else if (cfg_q[`FBR_WAIT_TIMING_BIT]) begin
      wact_d = (st_d == FBR_DATA) && ((wcnt_d > 2'h1) || ((wcnt_d == 2'h0) && !hold_d
               && pend_d && ((start_q[`FBR_ROW_BITS-1:0] + beat_d[`FBR_ROW_BITS-1:0]) == '0)
               && (beat_d != '0)));
    end else begin
      wact_d = (st_d == FBR_DATA) && (wcnt_d != 2'h0);
    end
    wait_d = cfg_q[`FBR_WAIT_POLARITY_BIT] ? wact_d : !wact_d;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_q   <= `FBR_CFG_RESET;
      st_q    <= FBR_IDLE;
      kclk_q  <= 1'b0;
      start_q <= '0;
      beat_q  <= '0;
      fidx_q  <= '0;
      lat_q   <= 3'h0;
      wcnt_q  <= 2'h0;
      hold_q  <= 1'b0;
      pend_q  <= 1'b0;
      outst_q <= 1'b0;
      req_q   <= 1'b0;
      raddr_q <= '0;
      dq_q    <= '0;
      oe_q    <= 1'b0;
      wact_q  <= 1'b1;
      wait_q  <= 1'b1;
    end else begin
      cfg_q   <= cfg_d;
      st_q    <= st_d;
      kclk_q  <= burst_clk;
      start_q <= start_d;
      beat_q  <= beat_d;
      fidx_q  <= (req_d && !flush) ? fidx_d + AW'(1) : fidx_d;
      lat_q   <= lat_d;
      wcnt_q  <= wcnt_d;
      hold_q  <= hold_d;
      pend_q  <= pend_d;
      outst_q <= outst_d;
      req_q   <= req_d;
      raddr_q <= raddr_d;
      dq_q    <= dq_d;
      oe_q    <= oe_d;
      wact_q  <= wact_d;
      wait_q  <= wait_d;
    end
  end

  assign cfg_rdata = cfg_q;
  assign dq_out    = dq_q;
  assign dq_oe     = oe_q;
  assign wait_out  = wait_q;
  assign arr_req   = req_q;
  assign arr_addr  = raddr_q;

  property p_async_wait;
    @(posedge clock) disable iff (sys_rst)
    // Pin follows the configuration of the cycle before, even across a write
    cfg_q[`FBR_READ_SELECT_BIT] |=> wait_q == $past(cfg_q[`FBR_WAIT_POLARITY_BIT]);
  endproperty
  a_async_wait: assert property (p_async_wait) else $error("async read without asserted wait");

  property p_polarity;
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> wait_q == ($past(cfg_q[`FBR_WAIT_POLARITY_BIT]) ? wact_q : !wact_q);
  endproperty
  a_polarity: assert property (p_polarity) else $error("wait pin polarity wrong");

  property p_aligned_nowait;
    @(posedge clock) disable iff (sys_rst)
    st_q == FBR_DATA && start_q[1:0] == 2'h0 && sync_rd |-> wcnt_q == 2'h0 && !wact_q;
  endproperty
  a_aligned_nowait: assert property (p_aligned_nowait) else $error("wait in aligned burst");

  property p_wait_len;
    @(posedge clock) disable iff (sys_rst)
    st_q == FBR_DATA && $past(wcnt_q) == 2'h0 && wcnt_q != 2'h0 |-> wcnt_q == start_q[1:0];
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("misalignment wait count wrong");

  property p_wait_once;
    @(posedge clock) disable iff (sys_rst)
    st_q == FBR_DATA && !pend_q && latch_en_n |=> !pend_q;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("second misalignment pause armed");

  property p_edge;
    @(posedge clock) disable iff (sys_rst)
    oe_q && $changed(dq_q) |-> $past(act_edge);
  endproperty
  a_edge: assert property (p_edge) else $error("data changed off the active edge");

  property p_latency;
    @(posedge clock) disable iff (sys_rst)
    st_q == FBR_ARMED && act_edge && !chip_en_n && latch_en_n && sync_rd
    |=> lat_q == $past(cfg_q[`FBR_LATENCY_MSB:`FBR_LATENCY_LSB]);
  endproperty
  a_latency: assert property (p_latency) else $error("latency not loaded");

  property p_length;
    @(posedge clock) disable iff (sys_rst)
    st_q == FBR_DATA && !cont |-> beat_q <= nwords;
  endproperty
  a_length: assert property (p_length) else $error("burst ran past its length");

  property p_hold;
    @(posedge clock) disable iff (sys_rst)
    pop && cfg_q[`FBR_DATA_HOLD_BIT] && !flush |=> hold_q;
  endproperty
  a_hold: assert property (p_hold) else $error("two-cycle hold not armed");

  property p_cov_cont;
    @(posedge clock) disable iff (sys_rst) st_q == FBR_DATA && cont && beat_q == AW'(20);
  endproperty
  c_cov_cont: cover property (p_cov_cont);

  property p_cov_wait;
    @(posedge clock) disable iff (sys_rst) wcnt_q == 2'h3;
  endproperty
  c_cov_wait: cover property (p_cov_wait);

  property p_cov_done;
    @(posedge clock) disable iff (sys_rst) st_q == FBR_DATA ##1 st_q == FBR_DONE;
  endproperty
  c_cov_done: cover property (p_cov_done);
endmodule

// >>> fbr_regs.svh
`ifndef FBR_REGS_SVH
`define FBR_REGS_SVH

// Burst read configuration register fields
`define FBR_READ_SELECT_BIT    15
`define FBR_LATENCY_MSB        13
`define FBR_LATENCY_LSB        11
`define FBR_WAIT_POLARITY_BIT  10
`define FBR_DATA_HOLD_BIT      9
`define FBR_WAIT_TIMING_BIT    8
`define FBR_BURST_TYPE_BIT     7
`define FBR_EDGE_SELECT_BIT    6
`define FBR_WRAP_SELECT_BIT    3
`define FBR_LENGTH_MSB         2
`define FBR_LENGTH_LSB         0

// Reset value and writable bits; bits 14, 5 and 4 stay zero
`define FBR_CFG_RESET          16'hBFCF
`define FBR_CFG_WMASK          16'hBFCF

// Burst length codes
`define FBR_LEN_4              3'h1
`define FBR_LEN_8              3'h2
`define FBR_LEN_16             3'h3
`define FBR_LEN_CONT           3'h7

// Sixteen-word boundary and four-word alignment
`define FBR_ROW_BITS           4
`define FBR_QUAD_BITS          2

`endif

// >>> fbr_pkg.sv
package fbr_pkg;

  typedef enum logic [2:0] {
    FBR_IDLE  = 3'b000,
    FBR_ARMED = 3'b001,
    FBR_LAT   = 3'b010,
    FBR_DATA  = 3'b011,
    FBR_DONE  = 3'b100
  } fbr_state_e;

  typedef logic [15:0] fbr_cfg_t;

endpackage

// >>> fbr_seq_if.sv
`timescale 1ns/1ps
interface fbr_seq_if #(parameter int AW = 21);
  logic [AW-1:0] start_addr;
  logic [AW-1:0] index;
  logic [2:0]    length;
  logic          wrap_select;
  logic          burst_type;
  logic [AW-1:0] addr;

  modport core (output start_addr, output index, output length, output wrap_select,
                output burst_type, input addr);
  modport gen  (input start_addr, input index, input length, input wrap_select,
                input burst_type, output addr);
endinterface

// >>> fbr_fifo.sv
`timescale 1ns/1ps
module fbr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             push, load;

  always_comb begin
    in_ready = (cnt_q != (PW+1)'(DEPTH)) && !flush;
    push     = in_valid && in_ready;
    load     = (cnt_q != '0) && (!ov_q || out_ready);
    wp_d     = wp_q;
    rp_d     = rp_q;
    cnt_d    = cnt_q;
    ov_d     = ov_q;
    od_d     = od_q;
    if (push) begin
      wp_d = wp_q + PW'(1);
    end
    if (out_ready && ov_q) begin
      ov_d = 1'b0;
    end
    // Output word sits in its own register
    if (load) begin
      od_d = mem_q[rp_q];
      ov_d = 1'b1;
      rp_d = rp_q + PW'(1);
    end
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(load);
    if (flush) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
      ov_d  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
    if (sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  assign out_valid = ov_q;
  assign out_data  = od_q;
endmodule

// >>> fbr_addr_gen.sv
`timescale 1ns/1ps
`include "fbr_regs.svh"
module fbr_addr_gen import fbr_pkg::*; #(
  parameter int AW = 21
) (
  // Sequence request and address
  fbr_seq_if.gen seq
);
  logic [AW-1:0] mask;
  logic [AW-1:0] sum;
  logic [AW-1:0] mix;

  always_comb begin
    case (seq.length)
      `FBR_LEN_4:  mask = AW'(3);
      `FBR_LEN_8:  mask = AW'(7);
      `FBR_LEN_16: mask = AW'(15);
      default:     mask = '0;
    endcase
    sum = seq.start_addr + seq.index;
    mix = seq.start_addr ^ seq.index;
    if (seq.length == `FBR_LEN_CONT) begin
      seq.addr = sum;
    end else if (!seq.burst_type) begin
      seq.addr = (seq.start_addr & ~mask) | (mix & mask);
    end else if (!seq.wrap_select) begin
      seq.addr = (seq.start_addr & ~mask) | (sum & mask);
    end else begin
      seq.addr = sum;
    end
  end
endmodule

// >>> fbr_host_model.sv
`timescale 1ns/1ps
module fbr_host_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Bench control
  input  wire logic        run,
  input  wire logic        slow,
  // Burst clock to the device
  output logic             burst_clk,
  // Array read port
  input  wire logic        arr_req,
  input  wire logic [20:0] arr_addr,
  output logic             arr_rvalid,
  output logic [15:0]      arr_rdata
);
  logic [1:0]  cnt_q;
  logic [2:0]  dly_q;
  logic [15:0] dat_q;

  // Burst clock stands low between frames
  assign burst_clk = run & cnt_q[1];
  // Released bus shows the inverse so a stale word never passes
  assign arr_rdata = arr_rvalid ? dat_q : ~dat_q;

  always_ff @(posedge clock) begin
    cnt_q      <= run ? cnt_q + 2'h1 : 2'h0;
    arr_rvalid <= 1'b0;
    if (sys_rst) begin
      dly_q <= 3'h0;
      dat_q <= 16'h0;
    end else if (arr_req) begin
      dly_q <= slow ? 3'h3 : 3'h1;
      dat_q <= arr_addr[15:0];
    end else if (dly_q != 3'h0) begin
      dly_q      <= dly_q - 3'h1;
      arr_rvalid <= (dly_q == 3'h1);
    end
  end
endmodule

// >>> flash_burst_read_config_tb.sv
`timescale 1ns/1ps
module flash_burst_read_config_tb;
  logic        clock      = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        cfg_wr     = 1'b0;
  logic [15:0] cfg_wdata  = 16'h0;
  logic        chip_en_n  = 1'b1;
  logic        latch_en_n = 1'b1;
  logic [20:0] addr_in    = 21'h0;
  logic        run        = 1'b0;
  logic        slow       = 1'b0;
  logic        burst_clk;
  logic [15:0] cfg_rdata;
  logic [15:0] dq_out;
  logic        dq_oe;
  logic        wait_out;
  logic        arr_req;
  logic [20:0] arr_addr;
  logic        arr_rvalid;
  logic [15:0] arr_rdata;
  int          n_mismatch = 0;
  int          checked    = 0;
  logic [15:0] got[$];
  int          tf, t2, tw, wclk, ta, tl2;

  always #12.5 clock = ~clock;

  fbr_top uut (
    .clock(clock), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .chip_en_n(chip_en_n), .latch_en_n(latch_en_n), .burst_clk(burst_clk), .addr_in(addr_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out), .arr_req(arr_req), .arr_addr(arr_addr),
    .arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata)
  );

  fbr_host_model u_host (
    .clock(clock), .sys_rst(sys_rst), .run(run), .slow(slow), .burst_clk(burst_clk),
    .arr_req(arr_req), .arr_addr(arr_addr), .arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata)
  );

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  function automatic logic [15:0] mk(int lat, int pol, int hold, int wt, int typ, int edg, int wrp, int len);
    return {2'b00, 3'(lat), 1'(pol), 1'(hold), 1'(wt), 1'(typ), 1'(edg), 2'b00, 1'(wrp), 3'(len)};
  endfunction

  // Expected address of beat i; wrap bit 1 means no wrap in linear bursts
  function automatic logic [20:0] ea(logic [20:0] s, logic [2:0] len, logic wrp, logic typ, int i);
    logic [20:0] m;
    m = (len == 3'h1) ? 21'h3 : (len == 3'h2) ? 21'h7 : (len == 3'h3) ? 21'hf : 21'h0;
    if (m == 21'h0 || (wrp && typ)) return s + 21'(i);
    return (s & ~m) | ((typ ? s + 21'(i) : s ^ 21'(i)) & m);
  endfunction

  task automatic cfg_write(input logic [15:0] d);
    cfg_wr    = 1'b1;
    cfg_wdata = d;
    @(posedge clock);
    #1;
    cfg_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Latch once, run the burst clock, gather distinct words and wait clocks
  task automatic burst(input logic [15:0] c, input logic [20:0] s, input int n);
    got.delete();
    tf   = 0;
    t2   = 0;
    tw   = 0;
    wclk = 0;
    cfg_write(c);
    chip_en_n  = 1'b0;
    latch_en_n = 1'b0;
    addr_in    = s;
    @(posedge clock);
    #1;
    latch_en_n = 1'b1;
    run        = 1'b1;
    for (int t = 1; t < 400 && got.size() < n; t++) begin
      @(posedge clock);
      #1;
      if (got.size() > 0 && wait_out === c[10]) begin
        if (wclk == 0) tw = t;
        wclk++;
      end
      if (dq_oe === 1'b1 && wait_out !== c[10] && (got.size() == 0 || dq_out !== got[$])) begin
        got.push_back(dq_out);
        if (got.size() == 1) tf = t;
        if (got.size() == 2) t2 = t;
      end
    end
    // Fixed bursts stop driving once their last word has stood
    if (c[2:0] != 3'h7) begin
      repeat (12) @(posedge clock);
      #1;
      chk16("oe_end", 16'h0, {15'h0, dq_oe});
    end
    chip_en_n = 1'b1;
    run       = 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic run_chk(input logic [15:0] c, input logic [20:0] s, input int n);
    logic [20:0] a;
    int          nw;
    burst(c, s, n);
    for (int i = 0; i < n; i++) begin
      a = ea(s, c[2:0], c[3], c[7], i);
      chk16("word", a[15:0], got[i]);
    end
    nw = 0;
    if ((c[2:0] == 3'h7 || (c[3] && c[7])) && ((s + 21'(n - 1)) >> 4) != (s >> 4)) nw = int'(s[1:0]);
    // Wait slots are one burst clock each, four system clocks
    chk_n("waits", nw, (wclk + 2) / 4);
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk16("cfg_reset", 16'hbfcf, cfg_rdata);
    chk16("wait_reset", 16'h1, {15'h0, wait_out});
    chk16("oe_reset", 16'h0, {15'h0, dq_oe});
    cfg_write(16'hffff);
    chk16("cfg_reserved", 16'hbfcf, cfg_rdata);
    cfg_write(16'h0000);
    chk16("cfg_clear", 16'h0, cfg_rdata);
    burst(16'hbfcf, 21'h0, 4);
    chk_n("async_words", 0, got.size());
    run_chk(mk(2, 1, 0, 0, 1, 1, 0, 1), 21'h7, 4);
    run_chk(mk(2, 1, 0, 0, 1, 1, 1, 1), 21'h7, 4);
    run_chk(mk(2, 1, 0, 0, 0, 1, 0, 1), 21'h1, 4);
    run_chk(mk(2, 1, 0, 0, 0, 1, 0, 2), 21'h2, 8);
    run_chk(mk(2, 1, 0, 1, 1, 1, 1, 3), 21'hd, 16);
    ta = tw;
    run_chk(mk(2, 1, 0, 0, 1, 1, 1, 3), 21'hd, 16);
    // Lead is one data cycle, four system clocks
    chk_n("wait_lead", 4, tw - ta);
    run_chk(mk(2, 0, 0, 0, 1, 1, 1, 3), 21'he, 16);
    run_chk(mk(2, 1, 0, 0, 1, 1, 1, 7), 21'hf, 20);
    slow = 1'b1;
    // Slow array keeps up only when each word stands two cycles
    run_chk(mk(2, 1, 1, 0, 1, 1, 1, 7), 21'h3_fffc, 8);
    slow = 1'b0;
    for (int l = 2; l < 6; l++) begin
      run_chk(mk(l, 1, 0, 0, 1, 1, 1, 1), 21'h0, 4);
      if (l == 2) tl2 = tf;
      if (l == 2) chk_n("hold_one", 4, t2 - tf);
      if (l > 2) chk_n("latency", 4, tf - ta);
      ta = tf;
    end
    run_chk(mk(2, 1, 0, 0, 1, 0, 1, 1), 21'h0, 4);
    chk_n("falling_edge", 2, tf - tl2);
    run_chk(mk(2, 1, 1, 0, 1, 1, 1, 1), 21'h0, 4);
    chk_n("hold_two", 8, t2 - tf);
    test_done();
  end
endmodule
